//--- verilog/edc_pkg.sv
package edc_pkg;
	// ============================================================
	// Geometry
	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;
	localparam int ROWS = 1024;
	// ============================================================
	// Timing in ns (power-up in us, refresh period in ms), as printed for the slower speed grade
	localparam int CLK_NS = 40;
	localparam int T_RAS_NS = 60;
	localparam int T_RP_NS = 40;
	localparam int T_RCD_NS = 14;
	localparam int T_CAS_NS = 15;
	localparam int T_CP_NS = 9;
	localparam int T_AR_NS = 40;
	localparam int T_CRP_NS = 5;
	localparam int T_PWRUP_US = 200;
	localparam int T_REF_MS = 16;
	localparam int INIT_CYCLES = 8;
	// ============================================================
	// Cycle counts: minimum times rounded up, refresh spacing rounded down
	localparam int C_RAS = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_RP = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_RCD = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_CAS = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_CP = (T_CP_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_AR = (T_AR_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_CRP = (T_CRP_NS + CLK_NS - 1) / CLK_NS;
	localparam int C_PWRUP = (T_PWRUP_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int C_REF_INT = (T_REF_MS * 1000000 / ROWS) / CLK_NS;
	localparam int CNT_W = 16;
	// ============================================================
	// Request opcodes on the command port
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_SELF_ENTER = 2'h2;
	localparam logic [1:0] OP_SELF_EXIT = 2'h3;
	localparam int FIFO_DEPTH = 8;
endpackage

//--- verilog/edc_fifo.sv
`timescale 1ns/1ps
module edc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	// ============================================================
	// Flags come straight from the occupancy count
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	// Storage has no reset; only the pointers and the count need a known value
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
			if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//--- verilog/edc_timer.sv
`timescale 1ns/1ps
module edc_timer #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic done
);
	logic [W-1:0] count;
	// ============================================================
	// Down counter; done is high once the loaded count has run out
	assign done = (count == '0);
	always_ff @(posedge clk) begin
		if (reset) begin
			count <= '0;
		end else if (load) begin
			count <= value;
		end else if (!done) begin
			count <= count - W'(1);
		end
	end
endmodule

//--- verilog/edc_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Cycle opens row strobe low, closes both high
// RULE2 - Hold row strobe low minimum row-active time
// RULE3 - Wait row precharge before next cycle
// RULE4 - Read starts at later column/output-gate fall
// RULE5 - Hold column address per row-referenced hold
// RULE6 - Device drives data after all access limits
// RULE7 - Write starts at later column/write fall
// RULE8 - Write data valid before first strobe falls; page-mode write columns drive data on the same edge as the strobes fall
// RULE9 - Issue 1,024 refreshes every 16 ms
// RULE10 - Row-only refresh covers every row per 128 ms
// RULE11 - Any row-strobed cycle refreshes that row
// RULE12 - Column-first refresh: column low before row falls
// RULE13 - Device uses internal counter, ignores address
// RULE14 - Column-first refresh leaves data lines floating
// RULE15 - Self refresh: column-first then hold row low
// RULE16 - Self refresh retains data over 128 ms
// RULE17 - Exit self refresh: row high precharge time
// RULE18 - Distributed refresh needs no burst after exit
// RULE19 - Page mode reaches any column of open row
// RULE20 - Page read data holds to next column fall
// RULE21 - Reads and writes mix within one page
// RULE22 - Wait 200 us, then eight row-strobe cycles
// RULE23 - Row then column share ten address pins
// RULE24 - Lower strobe bytes 0-7, upper 8-15
// RULE25 - Count clock cycles, round minimum times up
module edc_ctrl
	import edc_pkg::*;
#(
	parameter int PWRUP_CYCLES = C_PWRUP,
	parameter int REF_INTERVAL = C_REF_INT
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	// Request port
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic [1:0] REQ_OP,
	input wire logic [ADDR_W-1:0] REQ_ROW,
	input wire logic [ADDR_W-1:0] REQ_COL,
	input wire logic [1:0] REQ_BYTE_EN,
	input wire logic REQ_LAST,
	// Write data, buffered ahead of the memory
	input wire logic WDATA_VALID,
	output logic WDATA_READY,
	input wire logic [DATA_W-1:0] WDATA,
	// Read answer
	output logic RDATA_VALID,
	output logic [DATA_W-1:0] RDATA,
	output logic INIT_DONE,
	output logic IN_SELF_REFRESH,
	// Memory pins
	output logic ROW_STROBE_N,
	output logic LOWER_BYTE_COLUMN_STROBE_N,
	output logic UPPER_BYTE_COLUMN_STROBE_N,
	output logic WRITE_STROBE_N,
	output logic OUTPUT_GATE_N,
	output logic [ADDR_W-1:0] MEM_ADDR,
	input wire logic [DATA_W-1:0] MEM_DQ_IN,
	output logic [DATA_W-1:0] MEM_DQ_OUT,
	output logic MEM_DQ_OE
);
	typedef enum logic [3:0] {
		S_ARM, S_PWRUP, S_INIT_RAS, S_INIT_PRE, S_IDLE, S_ROW, S_COL, S_COL_HOLD,
		S_COL_PRE, S_PRE, S_REF_CAS, S_REF_RAS, S_SELF, S_SELF_EXIT
	} edc_state_e;
	edc_state_e state;
	edc_state_e next_state;
	logic [CNT_W-1:0] ref_cnt;
	logic ref_due;
	logic [3:0] init_cnt;
	logic is_write;
	logic [1:0] byte_en;
	logic [ADDR_W-1:0] col_addr;
	logic [DATA_W-1:0] fifo_data;
	logic fifo_valid;
	logic tmr_load;
	logic [CNT_W-1:0] tmr_value;
	logic tmr_done;
	logic ras_ok;
	logic [CNT_W-1:0] ras_cnt;
	logic close_after;
	logic [ADDR_W-1:0] open_row;
	wire fifo_pop = (state == S_COL) && is_write && tmr_done;
	// ============================================================
	// Write data FIFO; its ready reaches the data source
	edc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(CLK_SYS),
		.reset(RESET),
		.in_valid(WDATA_VALID),
		.in_ready(WDATA_READY),
		.in_data(WDATA),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);
	edc_timer #(.W(CNT_W)) u_tmr (
		.clk(CLK_SYS),
		.reset(RESET),
		.load(tmr_load),
		.value(tmr_value),
		.done(tmr_done)
	);
	// ============================================================
	// Request decode
	wire req_rw = REQ_VALID && (REQ_OP == OP_READ || REQ_OP == OP_WRITE);
	wire req_wr = REQ_OP == OP_WRITE;
	// A write is not started until its data sits in the FIFO
	wire req_go = req_rw && (!req_wr || fifo_valid);
	wire req_self_in = REQ_VALID && REQ_OP == OP_SELF_ENTER;
	wire req_self_out = REQ_VALID && REQ_OP == OP_SELF_EXIT;
	// Page goes on only in the open row, and only if the last column left it open
	wire page_hit = req_go && REQ_ROW == open_row && !close_after; // RULE19
	// ============================================================
	// Sequencing: timer guards the minimum intervals; ras_ok guards the row-active width before a page closes
	always_comb begin
		next_state = state;
		tmr_load = 1'b0;
		tmr_value = '0;
		case (state)
			S_ARM: begin
				next_state = S_PWRUP;
				tmr_load = 1'b1;
				tmr_value = CNT_W'(PWRUP_CYCLES); // RULE22
			end
			S_PWRUP: begin
				if (tmr_done) begin // RULE22
					next_state = S_INIT_RAS;
					tmr_load = 1'b1;
					tmr_value = CNT_W'(C_RAS);
				end
			end
			S_INIT_RAS: begin
				if (tmr_done) begin // RULE2
					next_state = S_INIT_PRE;
					tmr_load = 1'b1;
					tmr_value = CNT_W'(C_RP);
				end
			end
			S_INIT_PRE: begin
				if (tmr_done) begin // RULE3
					next_state = (init_cnt == 4'(INIT_CYCLES)) ? S_IDLE : S_INIT_RAS;
					tmr_load = (init_cnt != 4'(INIT_CYCLES));
					tmr_value = CNT_W'(C_RAS);
				end
			end
			S_IDLE: begin
				if (ref_due || req_self_in) begin // RULE9
					next_state = S_REF_CAS;
					tmr_load = 1'b1;
					tmr_value = CNT_W'(C_CRP);
				end else if (req_go) begin
					next_state = S_ROW;
					tmr_load = 1'b1;
					tmr_value = CNT_W'(C_RCD);
				end
			end
			S_ROW: begin
				if (tmr_done) begin
					next_state = S_COL;
					tmr_load = 1'b1;
					tmr_value = CNT_W'(C_CAS);
				end
			end
			S_COL: begin
				if (tmr_done) begin // RULE5
					next_state = S_COL_HOLD;
					tmr_load = 1'b1;
					tmr_value = CNT_W'(C_CP);
				end
			end
			S_COL_HOLD: begin
				// Column strobes high; page may continue with another column
				if (tmr_done && page_hit && !ref_due) begin // RULE21
					next_state = S_COL;
					tmr_load = 1'b1;
					tmr_value = CNT_W'(C_CAS);
				end else if (tmr_done && ras_ok) begin // RULE2
					next_state = S_PRE;
					tmr_load = 1'b1;
					tmr_value = CNT_W'(C_RP);
				end
			end
			S_PRE: begin
				if (tmr_done) next_state = S_IDLE; // RULE3
			end
			S_REF_CAS: begin
				if (tmr_done) begin // RULE12
					next_state = S_REF_RAS;
					tmr_load = 1'b1;
					tmr_value = CNT_W'(C_RAS);
				end
			end
			S_REF_RAS: begin
				if (tmr_done && req_self_in) begin // RULE15
					next_state = S_SELF;
				end else if (tmr_done) begin
					next_state = S_PRE;
					tmr_load = 1'b1;
					tmr_value = CNT_W'(C_RP);
				end
			end
			S_SELF: begin
				if (req_self_out) begin // RULE17
					next_state = S_SELF_EXIT;
					tmr_load = 1'b1;
					tmr_value = CNT_W'(C_RP);
				end
			end
			S_SELF_EXIT: begin
				if (tmr_done) next_state = S_IDLE; // RULE18
			end
			default: next_state = S_ARM;
		endcase
	end
	// ============================================================
	// State, init count and row-active tracking
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			state <= S_ARM;
			init_cnt <= '0;
		end else begin
			state <= next_state;
			if (state == S_INIT_RAS && tmr_done) init_cnt <= init_cnt + 4'h1; // RULE22
		end
	end
	// Row-active age lets page cycles end only after the minimum width
	assign ras_ok = (ras_cnt >= CNT_W'(C_RAS)); // RULE25
	always_ff @(posedge CLK_SYS) begin
		if (RESET || ROW_STROBE_N) begin
			ras_cnt <= CNT_W'(1);
		end else if (!ras_ok) begin
			ras_cnt <= ras_cnt + CNT_W'(1);
		end
	end
	// ============================================================
	// Distributed refresh: one column-first cycle per interval
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			ref_cnt <= '0;
			ref_due <= 1'b0;
		end else if (state == S_REF_CAS) begin
			ref_due <= 1'b0;
		end else if (ref_cnt == CNT_W'(REF_INTERVAL - 1)) begin
			ref_cnt <= '0;
			ref_due <= (state != S_SELF); // RULE9 RULE10
		end else begin
			ref_cnt <= ref_cnt + CNT_W'(1);
		end
	end
	// ============================================================
	// Latch the request when the row opens or a page column starts
	wire take = (state == S_IDLE && next_state == S_ROW) ||
		(state == S_COL_HOLD && next_state == S_COL);
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			is_write <= 1'b0;
			byte_en <= '0;
			col_addr <= '0;
		end else if (take) begin
			is_write <= req_wr;
			byte_en <= REQ_BYTE_EN;
			col_addr <= REQ_COL;
			close_after <= REQ_LAST;
			if (state == S_IDLE) open_row <= REQ_ROW;
		end
	end
	// ============================================================
	// Pin drive, all registered
	wire nx_ras_low = next_state inside {S_INIT_RAS, S_ROW, S_COL, S_COL_HOLD,
		S_REF_RAS, S_SELF}; // RULE1
	wire nx_cas_low = next_state inside {S_COL, S_REF_CAS, S_REF_RAS, S_SELF}; // RULE12
	wire nx_ref = next_state inside {S_REF_CAS, S_REF_RAS, S_SELF};
	wire nx_wr = take ? req_wr : is_write;
	wire [1:0] nx_be = take ? REQ_BYTE_EN : byte_en;
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			ROW_STROBE_N <= 1'b1;
			LOWER_BYTE_COLUMN_STROBE_N <= 1'b1;
			UPPER_BYTE_COLUMN_STROBE_N <= 1'b1;
		end else begin
			ROW_STROBE_N <= !nx_ras_low;
			LOWER_BYTE_COLUMN_STROBE_N <= !(nx_cas_low && (nx_ref || nx_be[0])); // RULE24
			UPPER_BYTE_COLUMN_STROBE_N <= !(nx_cas_low && (nx_ref || nx_be[1])); // RULE24
		end
	end
	// Write strobe and output gate settle with the column strobe edge
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			WRITE_STROBE_N <= 1'b1;
			OUTPUT_GATE_N <= 1'b1;
		end else begin
			WRITE_STROBE_N <= !(nx_cas_low && !nx_ref && nx_wr); // RULE7
			OUTPUT_GATE_N <= !(next_state inside {S_COL, S_COL_HOLD} && !nx_wr); // RULE4
		end
	end
	// Row address with the row strobe, column with the column strobe
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			MEM_ADDR <= '0;
		end else if (state == S_IDLE && next_state == S_ROW) begin
			MEM_ADDR <= REQ_ROW; // RULE23
		end else if (next_state == S_COL) begin
			MEM_ADDR <= take ? REQ_COL : col_addr; // RULE23
		end
	end
	// Data drives before the strobes fall on a row-opening write, on the same edge as them on a page column; first word already at FIFO head
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			MEM_DQ_OUT <= '0;
			MEM_DQ_OE <= 1'b0;
		end else begin
			MEM_DQ_OUT <= fifo_data; // RULE8
			MEM_DQ_OE <= nx_wr && next_state inside {S_ROW, S_COL}; // RULE8
		end
	end
	// ============================================================
	// Read capture at end of column pulse, data held until next column
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			RDATA_VALID <= 1'b0;
			RDATA <= '0;
		end else begin
			RDATA_VALID <= (state == S_COL) && tmr_done && !is_write; // RULE20
			if ((state == S_COL) && tmr_done && !is_write) RDATA <= MEM_DQ_IN; // RULE6
		end
	end
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			REQ_READY <= 1'b0;
			INIT_DONE <= 1'b0;
			IN_SELF_REFRESH <= 1'b0;
		end else begin
			REQ_READY <= take || (next_state == S_SELF && state != S_SELF) ||
				(next_state == S_SELF_EXIT && state == S_SELF);
			INIT_DONE <= INIT_DONE || (state == S_INIT_PRE && next_state == S_IDLE);
			IN_SELF_REFRESH <= (next_state == S_SELF); // RULE16
		end
	end
endmodule

//--- bench/edc_ctrl_properties.sv
`timescale 1ns/1ps
// ============================================================
// Pin protocol checker
module edc_ctrl_properties
	import edc_pkg::*;
#(
	parameter int PWRUP_CYCLES = C_PWRUP,
	parameter int REF_INTERVAL = C_REF_INT
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic INIT_DONE,
	input wire logic IN_SELF_REFRESH,
	input wire logic ROW_STROBE_N,
	input wire logic LOWER_BYTE_COLUMN_STROBE_N,
	input wire logic UPPER_BYTE_COLUMN_STROBE_N,
	input wire logic WRITE_STROBE_N,
	input wire logic OUTPUT_GATE_N,
	input wire logic MEM_DQ_OE
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	wire logic col_low = !LOWER_BYTE_COLUMN_STROBE_N || !UPPER_BYTE_COLUMN_STROBE_N;
	int lo_run;
	int hi_run;
	int since;
	int falls;
	logic ras_q;
	// Run lengths of the row strobe, kept in counters to avoid long repetitions
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			lo_run <= 0;
			hi_run <= 0;
			since <= 0;
			falls <= 0;
			ras_q <= 1'b1;
		end else begin
			lo_run <= ROW_STROBE_N ? 0 : lo_run + 1;
			hi_run <= ROW_STROBE_N ? hi_run + 1 : 0;
			since <= since + 1;
			falls <= falls + int'(ras_q && !ROW_STROBE_N);
			ras_q <= ROW_STROBE_N;
		end
	end
	ras_width_a: assert property ($rose(ROW_STROBE_N) |-> lo_run >= C_RAS)
		else $error("row strobe low too short");
	precharge_a: assert property ($fell(ROW_STROBE_N) |-> hi_run >= C_RP)
		else $error("row precharge too short");
	init_order_a: assert property ($rose(INIT_DONE) |-> since >= PWRUP_CYCLES && falls >= INIT_CYCLES)
		else $error("init done too early");
	init_hold_a: assert property (INIT_DONE |=> INIT_DONE)
		else $error("init done dropped");
	no_contend_a: assert property (MEM_DQ_OE |-> OUTPUT_GATE_N)
		else $error("data driven while output gate low");
	read_start_a: assert property ($fell(OUTPUT_GATE_N) |-> WRITE_STROBE_N && !ROW_STROBE_N)
		else $error("read started outside row cycle");
	write_data_a: assert property (!WRITE_STROBE_N && col_low && !ROW_STROBE_N |-> MEM_DQ_OE)
		else $error("write without data driven");
	cbr_quiet_a: assert property ($fell(ROW_STROBE_N) && col_low |-> !MEM_DQ_OE ##1 !MEM_DQ_OE)
		else $error("data driven in refresh");
	self_hold_a: assert property ($rose(IN_SELF_REFRESH) |-> !ROW_STROBE_N)
		else $error("self refresh without row low");
	cover property ($fell(OUTPUT_GATE_N));
	cover property (!WRITE_STROBE_N && col_low);
	cover property ($fell(ROW_STROBE_N) && col_low);
	cover property ($rose(IN_SELF_REFRESH));
endmodule

bind edc_ctrl edc_ctrl_properties #(
	.PWRUP_CYCLES(PWRUP_CYCLES),
	.REF_INTERVAL(REF_INTERVAL)
) props (
	.CLK_SYS(CLK_SYS), .RESET(RESET), .INIT_DONE(INIT_DONE),
	.IN_SELF_REFRESH(IN_SELF_REFRESH), .ROW_STROBE_N(ROW_STROBE_N),
	.LOWER_BYTE_COLUMN_STROBE_N(LOWER_BYTE_COLUMN_STROBE_N),
	.UPPER_BYTE_COLUMN_STROBE_N(UPPER_BYTE_COLUMN_STROBE_N),
	.WRITE_STROBE_N(WRITE_STROBE_N), .OUTPUT_GATE_N(OUTPUT_GATE_N),
	.MEM_DQ_OE(MEM_DQ_OE)
);

//--- bench/edc_mem_model.sv
`timescale 1ns/1ps
// ============================================================
// Memory model: strobes only, no clock
module edc_mem_model
	import edc_pkg::*;
(
	input wire logic ras_n,
	input wire logic lcs_n,
	input wire logic ucs_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] din,
	input wire logic din_oe,
	output logic [DATA_W-1:0] dq,
	output int cbr_cnt,
	output int ras_cnt,
	output int late_data
);
	logic [DATA_W-1:0] mem [int];
	logic [DATA_W-1:0] dout = '0;
	logic [ADDR_W-1:0] row = '0;
	logic [8:0] rcnt = '0;
	logic [1:0] en = '0;
	logic column_first_refresh = 1'b0;
	// Counters start clear
	initial begin
		cbr_cnt = 0;
		ras_cnt = 0;
		late_data = 0;
	end
	// Row fall latches the row, or refreshes from the own counter when a lane is low
	// Pins launched on the same clock edge are read one step later, after they settle
	always @(negedge ras_n) begin
		#1;
		ras_cnt++;
		column_first_refresh = !(lcs_n && ucs_n);
		if (column_first_refresh) begin
			cbr_cnt++;
			rcnt++;
		end else begin
			row = addr;
		end
	end
	// Row rise ends the cycle and releases the data lines
	always @(posedge ras_n) begin
		en = '0;
		column_first_refresh = 1'b0;
	end
	// The later of lane strobe and write strobe starts the access
	always @(negedge lcs_n or negedge we_n) #1 lane(0, lcs_n);
	always @(negedge ucs_n or negedge we_n) #1 lane(1, ucs_n);
	task automatic lane(input int b, input logic cs_n);
		int k;
		k = int'({row, addr});
		if (ras_n || column_first_refresh || cs_n) return;
		if (!mem.exists(k)) mem[k] = '0;
		if (!we_n) begin
			late_data += int'(!din_oe);
			mem[k][b*8 +: 8] = din[b*8 +: 8];
			en[b] = 1'b0;
		end else begin
			dout[b*8 +: 8] = mem[k][b*8 +: 8];
			en[b] = 1'b1;
		end
	endtask
	// Data shows after an access delay; a lane not driven shows the inverse, never a stale copy
	assign #5 dq = {(en[1] && !oe_n) ? dout[15:8] : ~dout[15:8],
		(en[0] && !oe_n) ? dout[7:0] : ~dout[7:0]};
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
// ============================================================
// Bench: controller, memory model, scoreboard
module tb_top;
	import edc_pkg::*;
	localparam int PWR = 100;
	localparam int REFI = 50;
	logic clk, reset, req_valid, req_last, wdata_valid;
	logic [1:0] req_op, req_be;
	logic [ADDR_W-1:0] req_row, req_col, row_a;
	logic [DATA_W-1:0] wdata;
	wire logic req_ready, wdata_ready, rdata_valid, init_done, in_self;
	wire logic ras_n, lcs_n, ucs_n, we_n, oe_n, dq_oe;
	wire logic [ADDR_W-1:0] mem_addr;
	wire logic [DATA_W-1:0] rdata, dq_in, dq_out;
	wire logic [4:0] flags = {wdata_ready, req_ready, ~in_self, in_self, init_done};
	int cbr_cnt, ras_cnt, late_data, fails, checked, n;
	logic [31:0] seed = 32'hD5F8EEEF;
	logic [DATA_W-1:0] shadow [int];
	logic [DATA_W-1:0] exp_q [$];
	logic [DATA_W-1:0] wq [$];
	logic [ADDR_W-1:0] cols [8];
	logic [1:0] be_tab [4] = '{2'h3, 2'h1, 2'h2, 2'h3};
	edc_ctrl #(.PWRUP_CYCLES(PWR), .REF_INTERVAL(REFI)) dut (
		.CLK_SYS(clk), .RESET(reset), .REQ_VALID(req_valid), .REQ_READY(req_ready),
		.REQ_OP(req_op), .REQ_ROW(req_row), .REQ_COL(req_col), .REQ_BYTE_EN(req_be),
		.REQ_LAST(req_last), .WDATA_VALID(wdata_valid), .WDATA_READY(wdata_ready),
		.WDATA(wdata), .RDATA_VALID(rdata_valid), .RDATA(rdata), .INIT_DONE(init_done),
		.IN_SELF_REFRESH(in_self), .ROW_STROBE_N(ras_n), .LOWER_BYTE_COLUMN_STROBE_N(lcs_n),
		.UPPER_BYTE_COLUMN_STROBE_N(ucs_n), .WRITE_STROBE_N(we_n), .OUTPUT_GATE_N(oe_n),
		.MEM_ADDR(mem_addr), .MEM_DQ_IN(dq_in), .MEM_DQ_OUT(dq_out), .MEM_DQ_OE(dq_oe)
	);
	edc_mem_model mem (
		.ras_n(ras_n), .lcs_n(lcs_n), .ucs_n(ucs_n), .we_n(we_n), .oe_n(oe_n),
		.addr(mem_addr), .din(dq_out), .din_oe(dq_oe), .dq(dq_in),
		.cbr_cnt(cbr_cnt), .ras_cnt(ras_cnt), .late_data(late_data)
	);
	// Clock at 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ============================================================
	// Helpers
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic bail();
		fails++;
		close_out();
	endtask
	// Bounded wait on one flag, checked mid-cycle where outputs are settled
	task automatic waitf(input int i);
		int k;
		k = 0;
		while (flags[i] !== 1'b1 && k < 5000) begin
			@(negedge clk);
			k++;
		end
		if (k >= 5000) bail();
	endtask
	task automatic req(input logic [1:0] op, input logic [9:0] r, input logic [9:0] c,
		input logic [1:0] be, input logic last);
		@(negedge clk);
		req_op = op;
		req_row = r;
		req_col = c;
		req_be = be;
		req_last = last;
		req_valid = 1'b1;
		waitf(3);
		req_valid = 1'b0;
	endtask
	task automatic push(input logic [15:0] d);
		@(negedge clk);
		wdata = d;
		wdata_valid = 1'b1;
		waitf(4);
		wq.push_back(d);
		@(negedge clk);
		wdata_valid = 1'b0;
	endtask
	task automatic wr(input logic [9:0] r, input logic [9:0] c, input logic [1:0] be,
		input logic last);
		int k;
		logic [15:0] d;
		k = int'({r, c});
		d = wq.pop_front();
		if (!shadow.exists(k)) shadow[k] = '0;
		if (be[0]) shadow[k][7:0] = d[7:0];
		if (be[1]) shadow[k][15:8] = d[15:8];
		req(OP_WRITE, r, c, be, last);
	endtask
	task automatic rd(input logic [9:0] r, input logic [9:0] c, input logic last);
		exp_q.push_back(shadow[int'({r, c})]);
		req(OP_READ, r, c, 2'h3, last);
	endtask
	// Scoreboard: each read answer takes the oldest expectation, sampled mid-cycle
	always @(negedge clk) begin
		if (rdata_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				bail();
			end else begin
				chk("read data", rdata, exp_q.pop_front());
			end
		end
	end
	// Watchdog against a hang outside the bounded waits
	initial begin
		repeat (60000) @(posedge clk);
		bail();
	end
	// ============================================================
	// Main sequence
	initial begin
		reset = 1'b1;
		req_valid = 1'b0;
		wdata_valid = 1'b0;
		req_op = OP_READ;
		req_row = '0;
		req_col = '0;
		req_be = 2'h3;
		req_last = 1'b1;
		wdata = '0;
		repeat (4) @(negedge clk);
		chk("idle pins", {11'h0, ras_n, lcs_n, ucs_n, we_n, dq_oe}, 16'h001E);
		reset = 1'b0;
		waitf(0);
		chk("init cycles", 16'(ras_cnt >= INIT_CYCLES), 16'h0001);
		for (int i = 0; i < FIFO_DEPTH; i++) push(16'(rnd()));
		@(negedge clk);
		wdata_valid = 1'b1;
		@(negedge clk);
		chk("fifo full", {15'h0, wdata_ready}, 16'h0000);
		wdata_valid = 1'b0;
		row_a = 10'(rnd());
		for (int i = 0; i < 8; i++) begin
			cols[i] = {7'(rnd()), 3'(i)};
			wr(row_a, cols[i], be_tab[i % 4], i == 7);
		end
		// Page mixes reads and writes on the same columns
		for (int i = 0; i < 8; i++) begin
			rd(row_a, cols[i], 1'b0);
			push(16'(rnd()));
			wr(row_a, cols[i], 2'h3, 1'b0);
			rd(row_a, cols[i], i == 7);
		end
		push(16'(rnd()));
		push(16'(rnd()));
		wr(~row_a, 10'h000, 2'h3, 1'b0);
		wr(~row_a, 10'h3FF, 2'h3, 1'b1);
		rd(~row_a, 10'h000, 1'b0);
		rd(~row_a, 10'h3FF, 1'b1);
		n = cbr_cnt;
		repeat (REFI * 10) @(negedge clk);
		chk("refresh count", 16'(cbr_cnt - n >= 9), 16'h0001);
		req(OP_SELF_ENTER, '0, '0, 2'h3, 1'b1);
		waitf(1);
		repeat (30) @(negedge clk);
		chk("self hold", {14'h0, ras_n, in_self}, 16'h0001);
		req(OP_SELF_EXIT, '0, '0, 2'h3, 1'b1);
		waitf(2);
		for (int i = 0; i < 8; i++) rd(row_a, cols[i], i == 7);
		n = 0;
		while (exp_q.size() != 0 && n < 500) begin
			@(negedge clk);
			n++;
		end
		chk("reads left", 16'(exp_q.size()), 16'h0000);
		chk("late write data", 16'(late_data), 16'h0000);
		close_out();
	end
endmodule
